// File: design/dpms_defines.svh
// Register offsets, field positions, reset values and timing counts
`ifndef DPMS_DEFINES_SVH
`define DPMS_DEFINES_SVH
// Byte offsets of the register words
`define OFS_POWER_LEVEL 8'h00
`define OFS_MISC_OUTPUT 8'h04
`define OFS_SUSP_CONFIG 8'h08
`define OFS_POWER_STAT 8'h0C
// Power level field in the monitor power level register
`define LVL_LO 1
`define LVL_HI 2
// Sync polarity bits in the misc output register
`define MISC_HPOL 6
`define MISC_VPOL 7
// Suspend configuration fields
`define CFG_HW_EN 2
`define CFG_SUSP_POL 3
`define CFG_SLOW_SRC 4
// Power status fields
`define STAT_SW_SUSP 2
`define STAT_HW_SUSP 4
`define STAT_TIMER 5
`define STAT_LVL_LO 6
`define STAT_LVL_HI 7
// Reset value of every register byte
`define REG_RESET 8'h00
// AXI responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
// Reference divide ratio for the derived slow clock
`define REF_DIVIDE 432
// Slow ticks per half period of the standby vertical train
`define VS_HALF_TICKS 256
`endif

// File: design/dpms_pkg.sv
// Types shared by the display power management block
package dpms_pkg;
  // Monitor power levels, in field order
  typedef enum logic [1:0] {LVL_ON, LVL_STANDBY, LVL_SUSPEND, LVL_OFF} level_type;
  // Outputs toward the monitor and the DAC
  typedef struct packed {
    logic hsync;
    logic vsync;
    logic dac_off;
  } sync_out_type;
endpackage

// File: design/dpms_sync_power_control.sv
// Monitor power level signalling with an AXI4-Lite register slave
//
// Notes on behaviour
// RULE1 - Field decodes four levels; zero is full on
// RULE2 - Standby: vsync 62.5 Hz, hsync idle, DAC off
// RULE3 - Suspend: vsync idle, hsync 32 kHz, DAC off
// RULE4 - Low bit set holds hsync at idle polarity
// RULE5 - High bit set holds vsync at idle polarity
// RULE6 - Any bit set powers the DAC down
// RULE7 - Timer standby forces standby, ignores field
// RULE8 - Hardware standby signals standby level
// RULE9 - Hardware suspend signals suspend level
// RULE10 - Level independent of flat panel power modes
// RULE11 - Slow clock sources the reduced-power sync pulses
// RULE12 - Hardware suspend refuses accesses; software suspend not
// RULE13 - External slow clock means reference turned off
// RULE14 - Host holds buses steady during suspend
// RULE15 - Select bit picks divided reference or pin
// RULE16 - Power level field resets to zero
`timescale 1ns/1ps
`include "dpms_defines.svh"
`default_nettype none
module dpms_sync_power_control
  import dpms_pkg::*;
#(
  parameter int ADDR_WIDTH = 8,
  parameter int REF_DIV = `REF_DIVIDE
)(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write channels
  input wire logic [ADDR_WIDTH-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read channels
  input wire logic [ADDR_WIDTH-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Active syncs from the CRT timing generator, same clock
  input wire logic hsync_in,
  input wire logic vsync_in,
  // Hardware power states: timer standby same clock, suspend from a pin
  input wire logic timer_standby,
  input wire logic suspend_pin,
  // Clock pins, sampled asynchronously
  input wire logic slow_clock_input,
  input wire logic ref_clock_input,
  // Monitor and DAC outputs
  output sync_out_type sync_out
);

  initial
  begin
    if (ADDR_WIDTH < 8 || REF_DIV < 2 || (REF_DIV % 2) != 0)
      $error("dpms_sync_power_control: unsupported parameter");
  end

  localparam int HALF_DIV = REF_DIV / 2;
  localparam logic [15:0] HALF_DIV_M1 = 16'(HALF_DIV - 1);
  localparam logic [7:0] VS_HALF_M1 = 8'(`VS_HALF_TICKS - 1);

  ////////////////////////////////////////////////////////////////////
  // Register storage
  logic [7:0] level_reg; // Monitor power level register
  logic [7:0] misc_reg; // Sync polarity bits
  logic [7:0] cfg_reg; // Suspend configuration register
  logic sw_susp_reg; // Software suspend request, status only
  sync_out_type sync_reg; // Registered monitor outputs

  ////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic susp_meta, susp_sync; // Suspend pin
  logic slow_meta, slow_sync; // External slow clock
  logic ref_meta, ref_sync, ref_prev; // Reference clock

  // Two flip-flops per pin before any logic looks at it
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      {susp_meta, susp_sync} <= 2'h0;
      {slow_meta, slow_sync} <= 2'h0;
      {ref_meta, ref_sync, ref_prev} <= 3'h0;
    end
    else
    begin
      {susp_meta, susp_sync} <= {suspend_pin, susp_meta};
      {slow_meta, slow_sync} <= {slow_clock_input, slow_meta};
      {ref_meta, ref_sync, ref_prev} <= {ref_clock_input, ref_meta, ref_sync};
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Slow clock: divided reference or external pin
  logic [15:0] div_cnt_reg; // Reference edges in this half period
  logic div_level_reg; // Derived slow clock level
  logic slow_prev_reg; // Last selected slow level
  wire ref_rise = ref_sync & ~ref_prev;
  // The reference is sampled well above twice its rate, edges are caught
  wire div_wrap = ref_rise && (div_cnt_reg == HALF_DIV_M1);
  wire slow_level = cfg_reg[`CFG_SLOW_SRC] ? div_level_reg : slow_sync; // RULE15
  wire slow_tick = slow_level & ~slow_prev_reg;

  // Divider toggles every half ratio of reference edges
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      div_cnt_reg <= 16'h0000;
      div_level_reg <= 1'b0;
      slow_prev_reg <= 1'b0;
    end
    else
    begin
      slow_prev_reg <= slow_level;
      if (div_wrap) // RULE15
      begin
        div_cnt_reg <= 16'h0000;
        div_level_reg <= ~div_level_reg;
      end
      else if (ref_rise)
        div_cnt_reg <= div_cnt_reg + 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Standby vertical train: slow clock divided by 512
  logic [7:0] vs_cnt_reg; // Slow ticks in this half period
  logic vs_train_reg; // 62.5 Hz square wave

  // Runs always, so entering standby needs no start-up
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      vs_cnt_reg <= 8'h00;
      vs_train_reg <= 1'b0;
    end
    else if (slow_tick) // RULE11
    begin
      vs_cnt_reg <= vs_cnt_reg + 8'h01;
      if (vs_cnt_reg == VS_HALF_M1)
        vs_train_reg <= ~vs_train_reg; // RULE2
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Effective level and sync selection
  // Polarity select set means an active-low pulse, so idle is high
  wire hpol = misc_reg[`MISC_HPOL];
  wire vpol = misc_reg[`MISC_VPOL];
  wire hw_suspend = cfg_reg[`CFG_HW_EN] &
                    (susp_sync ^ cfg_reg[`CFG_SUSP_POL]);
  wire [1:0] field = {level_reg[`LVL_HI], level_reg[`LVL_LO]}; // RULE1
  // Suspend outranks timer standby; flat panel modes never enter here
  wire level_type eff_level = hw_suspend ? LVL_SUSPEND : // RULE9 RULE12
                              timer_standby ? LVL_STANDBY : // RULE7 RULE8
                              level_type'(field); // RULE10
  wire [1:0] eff_bits = eff_level;
  wire h_next = eff_bits[0] ? hpol : // RULE4
                eff_bits[1] ? (slow_level ^ hpol) : // RULE3 RULE11
                (hsync_in ^ hpol); // RULE1
  wire v_next = eff_bits[1] ? vpol : // RULE5
                eff_bits[0] ? (vs_train_reg ^ vpol) : // RULE2 RULE7
                (vsync_in ^ vpol); // RULE1
  wire dac_next = |eff_bits; // RULE6

  // Outputs come straight from flip-flops
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      sync_reg <= '0;
    else
      sync_reg <= '{hsync: h_next, vsync: v_next, dac_off: dac_next};
  end
  assign sync_out = sync_reg;

  ////////////////////////////////////////////////////////////////////
  // AXI4-Lite write path
  logic aw_held_reg, w_held_reg; // Address or data taken, not yet used
  logic [7:0] waddr_reg; // Held write address, low byte
  logic [7:0] wbyte_reg; // Held write data, low byte
  logic wstrb0_reg; // Held strobe for the low byte
  logic awready_reg, wready_reg, bvalid_reg;
  logic [1:0] bresp_reg;
  wire aw_take = s_axi_awvalid & awready_reg;
  wire w_take = s_axi_wvalid & wready_reg;
  wire do_write = aw_held_reg & w_held_reg & ~bvalid_reg;
  wire w_hit = (waddr_reg == `OFS_POWER_LEVEL) |
               (waddr_reg == `OFS_MISC_OUTPUT) |
               (waddr_reg == `OFS_SUSP_CONFIG) |
               (waddr_reg == `OFS_POWER_STAT);
  wire w_ok = w_hit & ~hw_suspend; // RULE12
  wire w_en = do_write & w_ok & wstrb0_reg;

  // Channel handshakes; address and data taken in either order
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      {aw_held_reg, w_held_reg, bvalid_reg} <= 3'h0;
      {awready_reg, wready_reg} <= 2'h0;
      waddr_reg <= 8'h00;
      wbyte_reg <= 8'h00;
      wstrb0_reg <= 1'b0;
      bresp_reg <= `RESP_OKAY;
    end
    else
    begin
      awready_reg <= ~aw_take & ~aw_held_reg & ~bvalid_reg;
      wready_reg <= ~w_take & ~w_held_reg & ~bvalid_reg;
      if (aw_take)
      begin
        aw_held_reg <= 1'b1;
        waddr_reg <= s_axi_awaddr[7:0];
      end
      if (w_take)
      begin
        w_held_reg <= 1'b1;
        wbyte_reg <= s_axi_wdata[7:0];
        wstrb0_reg <= s_axi_wstrb[0];
      end
      if (do_write)
      begin
        {aw_held_reg, w_held_reg, bvalid_reg} <= 3'h1;
        bresp_reg <= w_ok ? `RESP_OKAY : `RESP_SLVERR; // RULE12
      end
      else if (bvalid_reg & s_axi_bready)
        bvalid_reg <= 1'b0;
    end
  end

  // Register writes; only the low byte carries bits
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      level_reg <= `REG_RESET; // RULE16
      misc_reg <= `REG_RESET;
      cfg_reg <= `REG_RESET;
      sw_susp_reg <= 1'b0;
    end
    else if (w_en)
    begin
      case (waddr_reg)
        `OFS_POWER_LEVEL: level_reg <= wbyte_reg & 8'h06;
        `OFS_MISC_OUTPUT: misc_reg <= wbyte_reg & 8'hC0;
        `OFS_SUSP_CONFIG: cfg_reg <= wbyte_reg & 8'h1C;
        `OFS_POWER_STAT: sw_susp_reg <= wbyte_reg[`STAT_SW_SUSP];
        default: sw_susp_reg <= sw_susp_reg;
      endcase
    end
  end

  assign s_axi_awready = awready_reg;
  assign s_axi_wready = wready_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;

  ////////////////////////////////////////////////////////////////////
  // AXI4-Lite read path
  logic arready_reg, rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;
  wire ar_take = s_axi_arvalid & arready_reg;
  wire [7:0] raddr = s_axi_araddr[7:0];
  wire [7:0] stat_byte = {eff_bits, timer_standby, hw_suspend, 1'b0,
                          sw_susp_reg, 2'h0};
  wire r_hit = (raddr == `OFS_POWER_LEVEL) | (raddr == `OFS_MISC_OUTPUT) |
               (raddr == `OFS_SUSP_CONFIG) | (raddr == `OFS_POWER_STAT);
  wire r_ok = r_hit & ~hw_suspend; // RULE12
  wire [7:0] rbyte = (raddr == `OFS_POWER_LEVEL) ? level_reg :
                     (raddr == `OFS_MISC_OUTPUT) ? misc_reg :
                     (raddr == `OFS_SUSP_CONFIG) ? cfg_reg : stat_byte;

  // One read at a time; refused reads return zero data
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      {arready_reg, rvalid_reg} <= 2'h0;
      rdata_reg <= 32'h00000000;
      rresp_reg <= `RESP_OKAY;
    end
    else
    begin
      arready_reg <= ~ar_take & ~rvalid_reg;
      if (ar_take)
      begin
        rvalid_reg <= 1'b1;
        rdata_reg <= r_ok ? {24'h000000, rbyte} : 32'h00000000;
        rresp_reg <= r_ok ? `RESP_OKAY : `RESP_SLVERR; // RULE12
      end
      else if (rvalid_reg & s_axi_rready)
        rvalid_reg <= 1'b0;
    end
  end

  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;

  ////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Sampled reset gates the start: the release edge still shows reset outputs
  a_full_on_dac: assert property ( // RULE1
    (aresetn && eff_level == LVL_ON) |=> !sync_reg.dac_off &&
      (sync_reg.hsync == ($past(hsync_in) ^ $past(hpol))))
    else $error("full on level lost DAC or hsync");
  a_standby_hsync_idle: assert property ( // RULE2
    (eff_level == LVL_STANDBY) |=> (sync_reg.hsync == $past(hpol)) &&
      (sync_reg.vsync == ($past(vs_train_reg) ^ $past(vpol))))
    else $error("standby syncs wrong");
  a_suspend_vsync_idle: assert property ( // RULE3
    (eff_level == LVL_SUSPEND) |=> (sync_reg.vsync == $past(vpol)) &&
      (sync_reg.hsync == ($past(slow_level) ^ $past(hpol))))
    else $error("suspend syncs wrong");
  a_low_bit_hidle: assert property ( // RULE4
    eff_bits[0] |=> sync_reg.hsync == $past(hpol))
    else $error("hsync not idle");
  a_high_bit_vidle: assert property ( // RULE5
    eff_bits[1] |=> sync_reg.vsync == $past(vpol))
    else $error("vsync not idle");
  a_dac_power_down: assert property ( // RULE6
    (eff_bits != 2'h0) |=> sync_reg.dac_off)
    else $error("DAC left powered");
  a_timer_forces_standby: assert property ( // RULE7
    (timer_standby && !hw_suspend) |-> eff_level == LVL_STANDBY)
    else $error("timer standby not forced");
  a_hw_suspend_level: assert property ( // RULE9
    hw_suspend |-> eff_level == LVL_SUSPEND)
    else $error("hardware suspend level wrong");
  a_refuse_in_suspend: assert property ( // RULE12
    (do_write && hw_suspend) |=> bvalid_reg &&
      bresp_reg == `RESP_SLVERR && $stable(level_reg))
    else $error("write accepted during hardware suspend");
  a_divider_toggle: assert property ( // RULE15
    div_wrap |=> div_level_reg != $past(div_level_reg))
    else $error("divider failed to toggle");
  a_train_toggle: assert property ( // RULE2
    (slow_tick && vs_cnt_reg == VS_HALF_M1) |=>
      vs_train_reg != $past(vs_train_reg))
    else $error("standby train failed to toggle");
  a_level_reset_zero: assert property ( // RULE16
    disable iff (1'b0) !aresetn |=> level_reg == `REG_RESET)
    else $error("power level not cleared by reset");

endmodule // dpms_sync_power_control
`default_nettype wire

// File: testbench/crt_monitor_model.sv
// Behavioural CRT monitor that watches the sync lines
`timescale 1ns/1ps
`default_nettype none
module crt_monitor_model
  import dpms_pkg::*;
(
  // Sampling clock
  input wire logic aclk,
  // Lines from the block
  input wire sync_out_type sync_out,
  // Edge counts and last vertical half period in cycles
  output var int hs_edges,
  output var int vs_edges,
  output var int vs_half
);
  sync_out_type prev; // Line levels one cycle back
  int since; // Cycles since the last vertical edge

  initial
  begin
    hs_edges = 0;
    vs_edges = 0;
    vs_half = 0;
    since = 0;
  end

  ////////////////////////////////////////////////////////////////////////
  // A monitor only sees level changes, so count edges and spacing
  always @(posedge aclk)
  begin
    prev <= sync_out;
    since <= since + 1;
    if (sync_out.hsync !== prev.hsync)
      hs_edges <= hs_edges + 1;
    if (sync_out.vsync !== prev.vsync)
    begin
      vs_edges <= vs_edges + 1;
      vs_half <= since;
      since <= 1;
    end
  end
endmodule // crt_monitor_model
`default_nettype wire

// File: testbench/tb.sv
// Self-checking bench for the monitor power level block
`timescale 1ns/1ps
`include "dpms_defines.svh"
`default_nettype none
module tb;
  import dpms_pkg::*;
  localparam int REF_DIV = 4; // Short divide keeps the trains fast
  logic aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = '0;
  logic [3:0] strb = 4'hF; // Strobe used by the next write
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic hsync_in = 1'b0, vsync_in = 1'b0, timer_standby = 1'b0;
  logic suspend_pin = 1'b0, slow_pin = 1'b0, ref_pin = 1'b0;
  logic ref_en = 1'b1, slow_en = 1'b0, h_d, v_d;
  sync_out_type sync_out;
  int error_cnt = 0, tests_run = 0, cyc = 0, seed = 96218, e0;
  int mreg[4] = '{0, 0, 0, 0}; // Model copy of the registers
  int mask[4] = '{32'h06, 32'hC0, 32'h1C, 32'h04}; // Writable bits

  dpms_sync_power_control #(.ADDR_WIDTH(8), .REF_DIV(REF_DIV)) i_dut (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .hsync_in, .vsync_in, .timer_standby,
    .suspend_pin, .slow_clock_input(slow_pin), .ref_clock_input(ref_pin),
    .sync_out);
  int hs_edges, vs_edges, vs_half;
  crt_monitor_model i_mon (.aclk, .sync_out, .hs_edges, .vs_edges,
    .vs_half);

  ////////////////////////////////////////////////////////////////////////
  // Clocks; the reference stands still while the pin clock is used
  always #12.5 aclk = ~aclk;
  always #35 ref_pin = ref_en ? ~ref_pin : ref_pin;
  always #250 slow_pin = slow_en ? ~slow_pin : slow_pin;

  // Random active syncs, and a one-cycle copy for the model
  always @(posedge aclk)
  begin
    hsync_in <= 1'($random(seed));
    vsync_in <= 1'($random(seed));
    h_d <= hsync_in;
    v_d <= vsync_in;
    cyc <= cyc + 1;
    if (cyc == 30000)
    begin
      error_cnt++;
      print_verdict();
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Model of hardware suspend, level priority and status
  function automatic bit hw_on();
    return mreg[2][2] && (suspend_pin ^ mreg[2][3]);
  endfunction
  function automatic int lvl();
    return hw_on() ? 2 : timer_standby ? 1 : mreg[0] >> 1;
  endfunction
  function automatic logic [1:0] exp_resp(input logic [7:0] a);
    return (hw_on() || a > 8'h0C || a[1:0] != 0) ? `RESP_SLVERR : `RESP_OKAY;
  endfunction

  task automatic check(input string name, input logic [31:0] seen,
    input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic print_verdict();
    $display("errors %0d of %0d checks", error_cnt, tests_run);
    if (error_cnt == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Bus cycles; addresses stay put between cycles, also run in suspend
  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] er;
    er = exp_resp(a);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= strb;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end
    while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    check("bresp", s_axi_bresp, er);
    // A clear low-byte strobe is answered but stores nothing
    if (er == `RESP_OKAY && strb[0]) mreg[a >> 2] = d & mask[a >> 2];
  endtask

  task automatic reg_read(input logic [7:0] a);
    logic [1:0] er;
    logic [31:0] ed;
    er = exp_resp(a);
    ed = (a == 8'h0C) ? (lvl() << 6 | timer_standby << 5 | hw_on() << 4
      | mreg[3]) : mreg[a >> 2];
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end
    while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    check("rresp", s_axi_rresp, er);
    check("rdata", s_axi_rdata, er == `RESP_OKAY ? ed : 32'h0);
  endtask

  // Idle lines at polarity, live lines follow the syncs, DAC by level
  task automatic sync_check(input int n);
    repeat (n)
    begin
      @(negedge aclk);
      check("dac_off", sync_out.dac_off, lvl() != 0);
      if (lvl() == 0) check("hsync", sync_out.hsync, h_d ^ mreg[1][6]);
      if (lvl() == 0) check("vsync", sync_out.vsync, v_d ^ mreg[1][7]);
      if (lvl() % 2) check("hsync", sync_out.hsync, mreg[1][6]);
      if (lvl() > 1) check("vsync", sync_out.vsync, mreg[1][7]);
    end
  endtask

  // Edges of hsync seen in 400 cycles against a window
  task automatic hs_count(input int lo, input int hi);
    e0 = hs_edges;
    repeat (400) @(posedge aclk);
    check("hs_edges", hs_edges - e0 >= lo && hs_edges - e0 <= hi, 1);
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    reg_read(8'h00);
    sync_check(8);
    for (int p = 0; p < 2; p++)
      for (int l = 0; l < 4; l++)
      begin
        reg_write(8'h04, $random(seed) & 32'hFFFFFF3F | p * 32'hC0);
        reg_write(8'h00, $random(seed) & 32'hFFFFFFF9 | l << 1);
        reg_read(8'h00);
        repeat (3) @(posedge aclk);
        sync_check(12);
      end
    reg_write(8'h12, 32'h5);
    reg_read(8'h10);
    reg_write(8'h08, 32'h10);
    reg_write(8'h00, 32'h4);
    hs_count(68, 75);
    ref_en = 0;
    slow_en = 1;
    reg_write(8'h08, 32'h0);
    hs_count(38, 42);
    slow_en = 0;
    ref_en = 1;
    // The pin clock is now still, so the train must run from the divider
    reg_write(8'h08, 32'h10);
    reg_write(8'h00, 32'h0);
    timer_standby <= 1'b1;
    repeat (3) @(posedge aclk);
    sync_check(8);
    reg_read(8'h0C);
    e0 = vs_edges;
    wait (vs_edges >= e0 + 2);
    check("vs_half", vs_half >= 2859 && vs_half <= 2875, 1);
    timer_standby <= 1'b0;
    reg_write(8'h0C, 32'hFF);
    reg_read(8'h0C);
    reg_write(8'h08, 32'h14);
    suspend_pin <= 1'b1;
    repeat (4) @(posedge aclk);
    sync_check(8);
    reg_write(8'h00, 32'h6);
    reg_read(8'h00);
    suspend_pin <= 1'b0;
    repeat (4) @(posedge aclk);
    reg_read(8'h00);
    strb = 4'hE; // Low byte strobe clear: taken, nothing stored
    reg_write(8'h00, 32'h6);
    strb = 4'hF;
    reg_read(8'h00);
    reg_write(8'h08, 32'h1C);
    repeat (4) @(posedge aclk);
    reg_read(8'h0C);
    suspend_pin <= 1'b1;
    repeat (4) @(posedge aclk);
    reg_read(8'h08);
    // Reset in mid-run must clear a level that was set
    reg_write(8'h00, 32'h2);
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    mreg = '{0, 0, 0, 0};
    reg_read(8'h00);
    reg_read(8'h08);
    print_verdict();
  end
endmodule // tb
`default_nettype wire
